// ==== hdl/isgs_defines.vh ====
`ifndef ISGS_DEFINES_VH
`define ISGS_DEFINES_VH

// Register byte addresses
`define ISGS_SETUP_ADDR 32'h50001394
`define ISGS_GCALL_ADDR 32'h50001398
`define ISGS_STATUS_ADDR 32'h5000139c
`define ISGS_ENABLE_ADDR 32'h500013c0
`define ISGS_OWNADDR_ADDR 32'h500013c4
`define ISGS_TXDATA_ADDR 32'h500013c8
`define ISGS_RXDATA_ADDR 32'h500013cc
`define ISGS_IRQSTAT_ADDR 32'h500013d0
`define ISGS_IRQMASK_ADDR 32'h500013d4

// Reset values
`define ISGS_SETUP_RST 8'h64
`define ISGS_GCALL_RST 1'h0
`define ISGS_ENABLE_RST 1'h0
`define ISGS_OWNADDR_RST 7'h2a
`define ISGS_TXDATA_RST 8'h00
`define ISGS_IRQMASK_RST 4'h0

// Status register fields
`define ISGS_ST_ACTIVE 0
`define ISGS_ST_BUSY_DIS 1
`define ISGS_ST_RX_LOST 2

// Interrupt status fields
`define ISGS_IRQ_RX 0
`define ISGS_IRQ_RD 1
`define ISGS_IRQ_GCALL 2
`define ISGS_IRQ_ABORT 3

// Bus constants
`define ISGS_GCALL_ADR 8'h00
`define ISGS_BITS_PER_BYTE 4'h8
`define ISGS_STRETCH_LAST 8'h01

`endif

// ==== hdl/isgs_core.v ====
// Functional notes
// - Slave-transmit holds the clock low for the setup count per bit.
// - The setup delay takes writes only while the controller is off.
// - Broadcast ack on: a general call is acked by driving data low.
// - Broadcast ack off: a general call raises no interrupt.
// - Switch-off in a matched receive with data sets the lost flag.
// - The lost flag is set once data phase began, even on a NACK.
// - The lost flag is also set when STOP comes before the NACK.
// - Switch-off during an address byte or receive data sets busy flag.
// - Once switched off, the controller NACKs whatever the address.
// - The busy flag is also set when STOP comes before the NACK.
// - The active status bit always mirrors the controller active output.
`timescale 1ns/1ps
`default_nettype none
`include "isgs_defines.vh"

module isgs_core (
   input wire ref_clk,
   input wire sys_rst,
   input wire [31:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg irq,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg controller_active_status
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_AACK = 3'd2;
   localparam [2:0] ST_RX = 3'd3;
   localparam [2:0] ST_RACK = 3'd4;
   localparam [2:0] ST_TX = 3'd5;
   localparam [2:0] ST_TACK = 3'd6;
   localparam [2:0] ST_WAIT = 3'd7;

   reg [7:0] setup_delay_field;
   reg broadcast_ack_enable;
   reg controller_on;
   reg [6:0] own_target_address;
   reg [7:0] tx_byte;
   reg [7:0] rx_byte;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg on_prev;
   reg receive_abort_flag;
   reg busy_disable_flag;
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shreg;
   reg rw_bit;
   reg data_phase;
   reg acked;
   reg [7:0] stretch_cnt;
   reg scl_d;
   reg sda_d;
   reg ev_rx;
   reg ev_rd;
   reg ev_gc;
   reg ev_ab;
   reg [15:0] rd_mux;

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire stat_rd;
   wire [3:0] events;
   wire [3:0] next_irq_stat;

   function in_rx_phase;
      input [2:0] st;
      begin
         in_rx_phase = (st == ST_RX) || (st == ST_RACK);
      end
   endfunction

   assign scl_rise = scl_in & ~scl_d;
   assign scl_fall = ~scl_in & scl_d;
   assign bus_start = scl_in & scl_d & sda_d & ~sda_in;
   assign bus_stop = scl_in & scl_d & ~sda_d & sda_in;
   assign stat_rd = reg_rd && (reg_addr == `ISGS_IRQSTAT_ADDR);
   assign events = {ev_ab, ev_gc, ev_rd, ev_rx};
   // A fresh event beats the clear-on-read
   assign next_irq_stat = (stat_rd ? 4'h0 : irq_stat) | events;

   ////////////////////////////////////////////////////////////////////////
   // Register file

   always @* begin
      case (reg_addr)
         `ISGS_SETUP_ADDR: rd_mux = {8'h00, setup_delay_field};
         `ISGS_GCALL_ADDR: rd_mux = {15'h0000, broadcast_ack_enable};
         `ISGS_STATUS_ADDR: rd_mux = {13'h0000, receive_abort_flag,
                                      busy_disable_flag, controller_active_status};
         `ISGS_ENABLE_ADDR: rd_mux = {15'h0000, controller_on};
         `ISGS_OWNADDR_ADDR: rd_mux = {9'h000, own_target_address};
         `ISGS_TXDATA_ADDR: rd_mux = {8'h00, tx_byte};
         `ISGS_RXDATA_ADDR: rd_mux = {8'h00, rx_byte};
         `ISGS_IRQSTAT_ADDR: rd_mux = {12'h000, irq_stat};
         `ISGS_IRQMASK_ADDR: rd_mux = {12'h000, irq_mask};
         default: rd_mux = 16'h0000;
      endcase
   end

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         setup_delay_field <= `ISGS_SETUP_RST;
         broadcast_ack_enable <= `ISGS_GCALL_RST;
         controller_on <= `ISGS_ENABLE_RST;
         own_target_address <= `ISGS_OWNADDR_RST;
         tx_byte <= `ISGS_TXDATA_RST;
         irq_mask <= `ISGS_IRQMASK_RST;
         irq_stat <= 4'h0;
         irq <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `ISGS_SETUP_ADDR: begin
                  // Delay change mid-transfer would corrupt timing
                  if (!controller_on) begin
                     setup_delay_field <= reg_wdata[7:0];
                  end
               end
               `ISGS_GCALL_ADDR: begin
                  broadcast_ack_enable <= reg_wdata[0];
               end
               `ISGS_ENABLE_ADDR: begin
                  controller_on <= reg_wdata[0];
               end
               `ISGS_OWNADDR_ADDR: begin
                  own_target_address <= reg_wdata[6:0];
               end
               `ISGS_TXDATA_ADDR: begin
                  tx_byte <= reg_wdata[7:0];
               end
               `ISGS_IRQMASK_ADDR: begin
                  irq_mask <= reg_wdata[3:0];
               end
               default: begin
               end
            endcase
         end
         irq_stat <= next_irq_stat;
         irq <= |(next_irq_stat & irq_mask);
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave engine

   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         rw_bit <= 1'b0;
         data_phase <= 1'b0;
         acked <= 1'b0;
         stretch_cnt <= 8'h00;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         rx_byte <= 8'h00;
         ev_rx <= 1'b0;
         ev_rd <= 1'b0;
         ev_gc <= 1'b0;
         ev_ab <= 1'b0;
         on_prev <= 1'b0;
         receive_abort_flag <= 1'b0;
         busy_disable_flag <= 1'b0;
         controller_active_status <= 1'b0;
      end else begin
         scl_d <= scl_in;
         sda_d <= sda_in;
         on_prev <= controller_on;
         ev_rx <= 1'b0;
         ev_rd <= 1'b0;
         ev_gc <= 1'b0;
         ev_ab <= 1'b0;
         controller_active_status <= controller_on |
                                     (state != ST_IDLE);
         if (bus_start && (controller_on || state != ST_IDLE)) begin
            // Restart after switch-off only waits for the STOP
            state <= controller_on ? ST_ADDR : ST_WAIT;
            bit_cnt <= 4'h0;
            data_phase <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
         end else if (bus_stop) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
         end else begin
            if (scl_oe) begin
               if (stretch_cnt > `ISGS_STRETCH_LAST) begin
                  stretch_cnt <= stretch_cnt - 8'h01;
               end else begin
                  scl_oe <= 1'b0;
               end
            end
            case (state)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_in};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `ISGS_BITS_PER_BYTE) begin
                     rw_bit <= shreg[0];
                     bit_cnt <= 4'h0;
                     state <= ST_AACK;
                     if (!controller_on) begin
                        sda_oe <= 1'b0;
                     end else if (shreg == `ISGS_GCALL_ADR) begin
                        sda_oe <= broadcast_ack_enable;
                        ev_gc <= broadcast_ack_enable;
                     end else begin
                        sda_oe <= (shreg[7:1] == own_target_address);
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     if (!sda_oe || !controller_on) begin
                        state <= ST_WAIT;
                     end else if (rw_bit) begin
                        // Byte must be preloaded; stretch gives no wait
                        state <= ST_TX;
                        ev_rd <= 1'b1;
                        shreg <= tx_byte;
                        sda_oe <= ~tx_byte[7];
                        scl_oe <= 1'b1;
                        stretch_cnt <= setup_delay_field;
                     end else begin
                        state <= ST_RX;
                        data_phase <= 1'b1;
                     end
                  end
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_in};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `ISGS_BITS_PER_BYTE) begin
                     bit_cnt <= 4'h0;
                     state <= ST_RACK;
                     if (controller_on) begin
                        sda_oe <= 1'b1;
                        rx_byte <= shreg;
                        ev_rx <= 1'b1;
                     end else begin
                        sda_oe <= 1'b0;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state <= (controller_on && sda_oe) ? ST_RX : ST_WAIT;
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt == `ISGS_BITS_PER_BYTE) begin
                        sda_oe <= 1'b0;
                        state <= ST_TACK;
                     end else begin
                        sda_oe <= ~shreg[7];
                        scl_oe <= 1'b1;
                        stretch_cnt <= setup_delay_field;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     acked <= ~sda_in;
                  end else if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (acked && controller_on) begin
                        state <= ST_TX;
                        ev_rd <= 1'b1;
                        shreg <= tx_byte;
                        sda_oe <= ~tx_byte[7];
                        scl_oe <= 1'b1;
                        stretch_cnt <= setup_delay_field;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end
               end
               ST_IDLE, ST_WAIT: begin
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
         // Flags latch at switch-off, so a later STOP cannot lose them
         if (on_prev && !controller_on) begin
            ev_ab <= 1'b1;
            if (state == ST_ADDR || state == ST_AACK ||
                (!rw_bit && in_rx_phase(state))) begin
               busy_disable_flag <= 1'b1;
            end
            if (data_phase && !rw_bit && in_rx_phase(state)) begin
               receive_abort_flag <= 1'b1;
            end
         end else if (!on_prev && controller_on) begin
            busy_disable_flag <= 1'b0;
            receive_abort_flag <= 1'b0;
         end
      end
   end

endmodule // isgs_core
`default_nettype wire

// ==== verif/isgs_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module isgs_master (
   input wire logic ref_clk,
   input wire logic dut_scl_oe,
   input wire logic dut_sda_oe,
   output wire logic scl_line,
   output wire logic sda_line
);
   localparam int HALF = 20;
   logic pull_scl = 1'h0;
   logic pull_sda = 1'h0;

   // Both lines have pull-ups: a released line reads high
   assign scl_line = ~(pull_scl | dut_scl_oe);
   assign sda_line = ~(pull_sda | dut_sda_oe);

   //////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic high_phase(output logic v);
      pull_scl <= 1'h0;
      tick(1);
      // Honour a stretch, but never hang on a stuck line
      for (int k = 0; k < 300 && !scl_line; k++) tick(1);
      tick(HALF);
      v = sda_line;
      pull_scl <= 1'h1;
      tick(2);
   endtask

   task automatic start;
      pull_sda <= 1'h1;
      tick(HALF);
      pull_scl <= 1'h1;
      tick(HALF);
   endtask

   task automatic stop;
      pull_sda <= 1'h1;
      tick(HALF);
      pull_scl <= 1'h0;
      tick(HALF);
      pull_sda <= 1'h0;
      tick(HALF);
   endtask

   // Sends n bits MSB first; a full byte also clocks the ack slot
   task automatic xfer(input logic [7:0] b, input int n, output logic ack,
                       output logic [7:0] rx);
      logic v;
      ack = 1'h0;
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         pull_sda <= ~b[7 - i];
         tick(HALF);
         high_phase(v);
         rx = {rx[6:0], v};
      end
      if (n == 8) begin
         pull_sda <= 1'h0;
         tick(HALF);
         high_phase(v);
         ack = ~v;
      end
   endtask
endmodule // isgs_master

`default_nettype wire

// ==== verif/isgs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isgs_defines.vh"

module isgs_asserts (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [31:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic controller_active_status
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_stretch_on;
      $rose(scl_oe);
   endsequence
   sequence s_read(a);
      reg_rd && reg_addr == a;
   endsequence

   //////////////////////////////
   a_sda_scl_high: assert property (
      scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   a_stretch_start: assert property (
      s_stretch_on |-> !$past(scl_in))
      else $error("stretch began with clock high");
   a_stretch_hold: assert property (s_stretch_on |=> scl_oe)
      else $error("stretch shorter than two cycles");
   a_stretch_bound: assert property (
      s_stretch_on |-> ##[1:256] !scl_oe)
      else $error("stretch longer than field range");
   a_status_mirror: assert property (
      s_read(`ISGS_STATUS_ADDR) |=>
      reg_rdata[0] == $past(controller_active_status))
      else $error("status bit does not follow active output");
   a_status_resvd: assert property (
      s_read(`ISGS_STATUS_ADDR) |=> reg_rdata[15:3] == 13'h0000)
      else $error("status reserved bits not zero");
   a_gcall_resvd: assert property (
      s_read(`ISGS_GCALL_ADDR) |=> reg_rdata[15:1] == 15'h0000)
      else $error("broadcast control reserved bits not zero");
   a_quiet_inactive: assert property (
      !controller_active_status |-> !sda_oe && !scl_oe)
      else $error("lines driven while inactive");
endmodule // isgs_asserts

bind isgs_core isgs_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .controller_active_status(controller_active_status));

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isgs_defines.vh"

module testbench;
   logic ref_clk, sys_rst, reg_wr, reg_rd, ack;
   logic [31:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic irq, scl_oe, sda_oe, active, scl_line, sda_line;
   logic scl_out, sda_out;
   logic [7:0] rx;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int run = 0;
   int max_run = 0;

   isgs_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .controller_active_status(active));
   isgs_master u_mst (.ref_clk(ref_clk), .dut_scl_oe(scl_oe),
      .dut_sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));

   //////////////////////////////
   task automatic end_sim;
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [15:0] e,
                     input string nm);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      chk(nm, e, reg_rdata);
   endtask

   task automatic irq_is(input logic e);
      // Mask write lands, then the registered irq follows
      repeat (3) @(posedge ref_clk);
      #1;
      chk("irq", {15'h0, e}, {15'h0, irq});
   endtask

   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Longest clock-stretch run seen on the wire
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      run <= scl_oe ? run + 1 : 0;
      if (scl_oe && run + 1 > max_run) max_run <= run + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      sys_rst = 1'h1;
      reg_addr = 32'h0;
      reg_wdata = 16'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'h0;
      rd(`ISGS_SETUP_ADDR, 16'h0064, "setup");
      rd(`ISGS_GCALL_ADDR, 16'h0000, "gcall");
      rd(32'h50001390, 16'h0000, "unmapped");
      wr(`ISGS_STATUS_ADDR, 16'hffff);
      rd(`ISGS_STATUS_ADDR, 16'h0000, "status");
      wr(`ISGS_SETUP_ADDR, 16'h0005);
      wr(`ISGS_ENABLE_ADDR, 16'h0001);
      wr(`ISGS_SETUP_ADDR, 16'h0009);
      rd(`ISGS_SETUP_ADDR, 16'h0005, "setup");
      rd(`ISGS_STATUS_ADDR, 16'h0001, "status");
      u_mst.start();
      u_mst.xfer(8'h54, 8, ack, rx);
      chk("ack", 16'h0001, {15'h0, ack});
      u_mst.xfer(8'hc3, 8, ack, rx);
      u_mst.stop();
      rd(`ISGS_RXDATA_ADDR, 16'h00c3, "rxdata");
      irq_is(1'h0);
      wr(`ISGS_IRQMASK_ADDR, 16'h0001);
      irq_is(1'h1);
      rd(`ISGS_IRQSTAT_ADDR, 16'h0001, "irqstat");
      irq_is(1'h0);
      for (int g = 0; g < 2; g++) begin
         wr(`ISGS_GCALL_ADDR, {15'h0, g[0]});
         u_mst.start();
         u_mst.xfer(8'h00, 8, ack, rx);
         u_mst.stop();
         chk("gcall ack", {15'h0, g[0]}, {15'h0, ack});
         rd(`ISGS_IRQSTAT_ADDR, {13'h0, g[0], 2'h0}, "irqstat");
      end
      // Read: every data bit is launched under a stretch
      wr(`ISGS_TXDATA_ADDR, 16'h00a5);
      u_mst.start();
      u_mst.xfer(8'h55, 8, ack, rx);
      u_mst.xfer(8'hff, 8, ack, rx);
      u_mst.stop();
      chk("txdata", 16'h00a5, {8'h0, rx});
      chk("stretch", 16'h0005, max_run[15:0]);
      // Disable in the data phase: full byte NACKed, or STOP first
      for (int n = 3; n <= 8; n += 5) begin
         wr(`ISGS_ENABLE_ADDR, 16'h0001);
         u_mst.start();
         u_mst.xfer(8'h54, 8, ack, rx);
         u_mst.xfer(8'h11, 8, ack, rx);
         wr(`ISGS_ENABLE_ADDR, 16'h0000);
         u_mst.xfer(8'h22, n, ack, rx);
         chk("nack", 16'h0000, {14'h0, ack, sda_oe});
         u_mst.stop();
         chk("active", 16'h0000, {15'h0, active});
         rd(`ISGS_STATUS_ADDR, 16'h0006, "abort");
      end
      wr(`ISGS_ENABLE_ADDR, 16'h0001);
      rd(`ISGS_STATUS_ADDR, 16'h0001, "reenable");
      chk("active", 16'h0001, {15'h0, active});
      // Disable in the address byte, then STOP before any NACK
      u_mst.start();
      u_mst.xfer(8'h54, 4, ack, rx);
      wr(`ISGS_ENABLE_ADDR, 16'h0000);
      u_mst.stop();
      rd(`ISGS_STATUS_ADDR, 16'h0002, "busy");
      chk("drive levels", 16'h0000, {14'h0, scl_out, sda_out});
      end_sim();
   end
endmodule // testbench

`default_nettype wire
